/* File: logic/burst_sram_defines.svh */
// constants for the burst static memory control block
`ifndef BURST_SRAM_DEFINES_SVH
`define BURST_SRAM_DEFINES_SVH

// ****************************************
// organisation
// ****************************************
`define SRAM_WORDS 65536
`define SRAM_ADDR_W 16
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_CNT_W 2
`define SRAM_NO_LANES 4'h0
`define SRAM_ALL_LANES 4'hf

// ****************************************
// output buffer
// ****************************************
`define BUF_DEPTH 2
`define BUF_CNT_W 2

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 40
`define SNOOZE_WAKE_NS 100
`define SNOOZE_WAKE_CYCLES ((`SNOOZE_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_CNT_W 8

`endif

/* File: logic/burst_sram_pkg.sv */
// types shared by the burst static memory control block
package burst_sram_pkg;

    // power states
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SNOOZE,
        PWR_WAKE
    } pwr_t;

endpackage

/* File: logic/word_stream_if.sv */
// valid/ready word stream between the read stage and the output stage
`timescale 1ns/1ps
`include "burst_sram_defines.svh"

interface word_stream_if;
    logic valid;
    logic ready;
    logic [`SRAM_DATA_W-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );

    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

/* File: logic/word_buffer2.sv */
// two-entry word buffer with flush
`timescale 1ns/1ps
`include "burst_sram_defines.svh"

module word_buffer2 (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_flush,
    // streams
    word_stream_if.snk fill,
    word_stream_if.src drain
);

    // ****************************************
    // storage
    // ****************************************
    logic [`SRAM_DATA_W-1:0] ent_r [`BUF_DEPTH];
    logic [`SRAM_DATA_W-1:0] ent_nxt [`BUF_DEPTH];
    logic wp_r;
    logic wp_nxt;
    logic rp_r;
    logic rp_nxt;
    logic [`BUF_CNT_W-1:0] cnt_r;
    logic [`BUF_CNT_W-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign fill.ready = (cnt_r != 2'(`BUF_DEPTH));
    assign drain.valid = (cnt_r != 2'h0);
    assign drain.data = ent_r[rp_r];

    always_comb begin
        push = fill.valid && fill.ready;
        pop = drain.valid && drain.ready;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (i_flush) begin
            wp_nxt = 1'b0;
            rp_nxt = 1'b0;
            cnt_nxt = 2'h0;
        end else begin
            if (push) begin
                wp_nxt = ~wp_r;
            end
            if (pop) begin
                rp_nxt = ~rp_r;
            end
            cnt_nxt = cnt_r + 2'(push) - 2'(pop);
        end
    end

    // ****************************************
    // entries
    // ****************************************
    generate
        for (genvar g = 0; g < `BUF_DEPTH; g++) begin : gen_ent
            always_comb begin
                ent_nxt[g] = ent_r[g];
                if (push && !i_flush && (wp_r == 1'(g))) begin
                    ent_nxt[g] = fill.data;
                end
            end
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ent_r[g] <= 32'h0;
                end else begin
                    ent_r[g] <= ent_nxt[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule

/* File: logic/sync_burst_sram_control.sv */
// burst static memory: decode, burst counter, array and output stage
`timescale 1ns/1ps
`include "burst_sram_defines.svh"

// What this block does
// - store 65,536 words of 32 bits, 16-bit address, four byte lanes
// - two-bit burst counter loaded at access start gives the low address bits
// - burst order select low gives linear order, high gives interleaved order
// - flow-through select low skips the output register, high pipelines the data
// - latency mode select low is fast release, high is sustained output
// - sustained output keeps read data one more cycle after deselect by selects two/three
// - fast release turns data outputs off within one cycle after that deselect
// - processor strobe with selects 0/1/0 starts a read, ignoring write controls
// - controller strobe with all selects active starts a read or write
// - a strobe with bad second or third select deselects, loads nothing, floats bus after any sustained word
// - without a start, advance low steps the counter, advance high holds the address
// - continue and suspend cycles read or write as write controls say; writes float bus
// - all inputs but reset sampled on the clock; output drive enable gates driving of read data
// - snooze request is asynchronous in intent and places the device in retention
// - interleaved order xors the count, linear order adds it modulo four
// - global write writes all bytes, else gate low writes each enabled lane
// - lane enables are captured with the write data
// - in snooze, data is kept and inputs ignored until wake period passes
module sync_burst_sram_control (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // address and data
    input wire logic [`SRAM_ADDR_W-1:0] i_addr,
    input wire logic [`SRAM_DATA_W-1:0] i_dq_in,
    output logic [`SRAM_DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    // strobes and selects
    input wire logic i_processor_address_strobe_n,
    input wire logic i_controller_address_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_first_chip_select_n,
    input wire logic i_second_chip_select,
    input wire logic i_third_chip_select_n,
    // write controls
    input wire logic i_global_write_all_n,
    input wire logic i_byte_write_gate_n,
    input wire logic [`SRAM_LANES-1:0] i_byte_lane_enables_n,
    input wire logic i_output_drive_enable_n,
    // static modes and snooze
    input wire logic i_burst_order_select,
    input wire logic i_flow_through_select,
    input wire logic i_latency_mode_select,
    input wire logic i_snooze_request,
    // status
    output logic o_selected,
    output logic o_snooze_active
);

    // ****************************************
    // declarations
    // ****************************************
    burst_sram_pkg::pwr_t pwr_r;
    burst_sram_pkg::pwr_t pwr_nxt;
    logic [`WAKE_CNT_W-1:0] wake_r;
    logic [`WAKE_CNT_W-1:0] wake_nxt;
    logic active_r;
    logic active_nxt;
    logic [`SRAM_ADDR_W-3:0] base_r;
    logic [`SRAM_ADDR_W-3:0] base_nxt;
    logic [`SRAM_CNT_W-1:0] start_r;
    logic [`SRAM_CNT_W-1:0] start_nxt;
    logic [`SRAM_CNT_W-1:0] cnt_r;
    logic [`SRAM_CNT_W-1:0] cnt_nxt;
    logic [`SRAM_DATA_W-1:0] dq_r;
    logic [`SRAM_DATA_W-1:0] dq_nxt;
    logic oe_r;
    logic oe_nxt;
    logic valid_r;
    logic valid_nxt;
    logic held_r;
    logic held_nxt;
    logic [`SRAM_ADDR_W-1:0] peek_r;
    logic run;
    logic ext;
    logic sel_ok;
    logic proc_start;
    logic begin_acc;
    logic desel;
    logic desel23;
    logic cont;
    logic wr_req;
    logic is_write;
    logic rd_fire;
    logic fast;
    logic flush;
    logic [`SRAM_LANES-1:0] lanes;
    logic [`SRAM_CNT_W-1:0] low;
    logic [`SRAM_ADDR_W-1:0] acc_addr;
    logic [`SRAM_DATA_W-1:0] rd_word;
    logic [`SRAM_DATA_W-1:0] peek_word;

    word_stream_if rd_stream ();
    word_stream_if out_stream ();

    // ****************************************
    // cycle decode and burst counter
    // ****************************************
    always_comb begin
        run = (pwr_r == burst_sram_pkg::PWR_RUN) && !i_snooze_request;
        proc_start = !i_processor_address_strobe_n && !i_first_chip_select_n;
        ext = proc_start || !i_controller_address_strobe_n;
        sel_ok = i_second_chip_select && !i_third_chip_select_n;
        begin_acc = run && ext && !i_first_chip_select_n && sel_ok;
        desel = run && ext && !begin_acc;
        desel23 = desel && !i_first_chip_select_n;
        cont = run && !ext && active_r;
        wr_req = !i_global_write_all_n || (!i_byte_write_gate_n && (i_byte_lane_enables_n != `SRAM_ALL_LANES));
        if (!i_global_write_all_n) begin
            lanes = `SRAM_ALL_LANES;
        end else if (!i_byte_write_gate_n) begin
            lanes = ~i_byte_lane_enables_n;
        end else begin
            lanes = `SRAM_NO_LANES;
        end
        is_write = (begin_acc && !proc_start && wr_req) || (cont && wr_req);
        rd_fire = (begin_acc || cont) && !is_write;
        fast = !i_latency_mode_select;
        flush = is_write || !run || (fast && desel23);
        active_nxt = active_r;
        base_nxt = base_r;
        start_nxt = start_r;
        cnt_nxt = cnt_r;
        if (begin_acc) begin
            active_nxt = 1'b1;
            base_nxt = i_addr[`SRAM_ADDR_W-1:2];
            start_nxt = i_addr[1:0];
            cnt_nxt = 2'h0;
        end else if (desel) begin
            active_nxt = 1'b0;
        end else if (cont && !i_burst_advance_n && rd_stream.ready) begin
            cnt_nxt = cnt_r + 2'h1;
        end
        if (i_burst_order_select) begin
            low = start_nxt ^ cnt_nxt;
        end else begin
            low = start_nxt + cnt_nxt;
        end
        acc_addr = {base_nxt, low};
    end

    // ****************************************
    // storage array, one per byte lane
    // ****************************************
    generate
        for (genvar g = 0; g < `SRAM_LANES; g++) begin : gen_lane
            logic [`SRAM_LANE_W-1:0] mem [`SRAM_WORDS];
            assign rd_word[g*`SRAM_LANE_W +: `SRAM_LANE_W] = mem[acc_addr];
            assign peek_word[g*`SRAM_LANE_W +: `SRAM_LANE_W] = mem[peek_r];
            always_ff @(posedge i_clk) begin
                if (is_write && lanes[g]) begin
                    mem[acc_addr] <= i_dq_in[g*`SRAM_LANE_W +: `SRAM_LANE_W];
                end
            end
        end
    endgenerate

    // ****************************************
    // read path: buffer for the pipelined stage
    // ****************************************
    assign rd_stream.valid = rd_fire && i_flow_through_select;
    assign rd_stream.data = rd_word;
    assign out_stream.ready = 1'b1;

    word_buffer2 u_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_flush(flush),
        .fill(rd_stream.snk),
        .drain(out_stream.src)
    );

    // ****************************************
    // output stage
    // ****************************************
    always_comb begin
        dq_nxt = dq_r;
        valid_nxt = 1'b0;
        held_nxt = 1'b0;
        if (!i_flow_through_select) begin
            if (rd_fire) begin
                dq_nxt = rd_word;
                valid_nxt = 1'b1;
            end else if (!fast && desel23 && valid_r && !held_r) begin
                valid_nxt = 1'b1;
                held_nxt = 1'b1;
            end
        end else if (out_stream.valid && !flush) begin
            dq_nxt = out_stream.data;
            valid_nxt = 1'b1;
        end
        oe_nxt = valid_nxt && !i_output_drive_enable_n && !is_write;
    end

    // ****************************************
    // snooze control
    // ****************************************
    always_comb begin
        pwr_nxt = pwr_r;
        wake_nxt = wake_r;
        case (pwr_r)
            burst_sram_pkg::PWR_RUN: begin
                if (i_snooze_request) begin
                    pwr_nxt = burst_sram_pkg::PWR_SNOOZE;
                end
            end
            burst_sram_pkg::PWR_SNOOZE: begin
                wake_nxt = 8'h0;
                if (!i_snooze_request) begin
                    pwr_nxt = burst_sram_pkg::PWR_WAKE;
                end
            end
            default: begin
                if (i_snooze_request) begin
                    pwr_nxt = burst_sram_pkg::PWR_SNOOZE;
                end else if (wake_r == 8'(`SNOOZE_WAKE_CYCLES - 1)) begin
                    pwr_nxt = burst_sram_pkg::PWR_RUN;
                end else begin
                    wake_nxt = wake_r + 8'h1;
                end
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_r <= burst_sram_pkg::PWR_RUN;
            wake_r <= 8'h0;
            active_r <= 1'b0;
            base_r <= 14'h0;
            start_r <= 2'h0;
            cnt_r <= 2'h0;
            dq_r <= 32'h0;
            oe_r <= 1'b0;
            valid_r <= 1'b0;
            held_r <= 1'b0;
            peek_r <= 16'h0;
            o_selected <= 1'b0;
            o_snooze_active <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            wake_r <= wake_nxt;
            active_r <= active_nxt;
            base_r <= base_nxt;
            start_r <= start_nxt;
            cnt_r <= cnt_nxt;
            dq_r <= dq_nxt;
            oe_r <= oe_nxt;
            valid_r <= valid_nxt;
            held_r <= held_nxt;
            peek_r <= acc_addr;
            o_selected <= active_nxt;
            o_snooze_active <= (pwr_nxt != burst_sram_pkg::PWR_RUN);
        end
    end

    assign o_dq_out = dq_r;
    assign o_dq_oe = oe_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_flow_read_latency: assert property (
        !i_flow_through_select && rd_fire && !i_output_drive_enable_n |=> o_dq_oe && o_dq_out == $past(rd_word))
        else $error("flow-through read data not driven next cycle");
    a_pipe_read_latency: assert property (
        i_flow_through_select && rd_fire ##1 (!flush && !i_output_drive_enable_n && !is_write)
        |=> o_dq_oe && o_dq_out == $past(rd_word, 2))
        else $error("pipelined read data not driven two cycles later");
    a_write_floats_bus: assert property (
        is_write |=> !o_dq_oe)
        else $error("bus driven after a write cycle");
    a_fast_release_off: assert property (
        fast && desel23 |=> !o_dq_oe)
        else $error("fast release still drives after deselect");
    a_sustain_one_more: assert property (
        !fast && desel23 && out_stream.valid && !i_output_drive_enable_n && i_flow_through_select
        |=> o_dq_oe)
        else $error("sustained output dropped data at deselect");
    a_burst_step_wrap: assert property (
        cont && !i_burst_advance_n && rd_stream.ready |=> cnt_r == 2'($past(cnt_r) + 2'h1))
        else $error("burst counter did not step");
    a_burst_hold: assert property (
        cont && i_burst_advance_n |=> $stable(cnt_r) && $stable(start_r) && $stable(base_r))
        else $error("suspend cycle moved the address");
    a_begin_load_addr: assert property (
        begin_acc |=> cnt_r == 2'h0 && start_r == $past(i_addr[1:0]) && o_selected)
        else $error("start did not load the address");
    a_deselect_no_load: assert property (
        desel |=> !o_selected && $stable(base_r) && (!o_dq_oe || $past(!fast || i_flow_through_select))
        ##1 (!o_dq_oe || $past(begin_acc)))
        else $error("deselect loaded an address or drove the bus");
    a_global_write_all: assert property (
        is_write && !i_global_write_all_n |=> peek_word == $past(i_dq_in))
        else $error("global write missed a byte");
    a_snooze_ignores: assert property (
        o_snooze_active && i_snooze_request |=> $stable(base_r) && $stable(cnt_r) && !o_dq_oe)
        else $error("inputs acted during snooze");

    c_burst_read: cover property (begin_acc && !is_write ##1 cont [*3]);
    c_byte_write: cover property (is_write && i_global_write_all_n);
    c_sustain_desel: cover property (!fast && desel23 && valid_r);
    c_snooze_wake: cover property (o_snooze_active ##1 !o_snooze_active);

endmodule

/* File: tb/host_bus_model.sv */
// host bus model that drives the burst memory pins
`timescale 1ns/1ps
`include "burst_sram_defines.svh"

module host_bus_model (
    // clock
    input wire logic i_clk,
    // address and data
    output logic [`SRAM_ADDR_W-1:0] o_addr,
    output logic [`SRAM_DATA_W-1:0] o_dq,
    // strobes and selects
    output logic o_processor_address_strobe_n,
    output logic o_controller_address_strobe_n,
    output logic o_burst_advance_n,
    output logic o_first_chip_select_n,
    output logic o_second_chip_select,
    output logic o_third_chip_select_n,
    // write controls
    output logic o_global_write_all_n,
    output logic o_byte_write_gate_n,
    output logic [`SRAM_LANES-1:0] o_byte_lane_enables_n,
    output logic o_output_drive_enable_n,
    // static modes and snooze
    output logic o_burst_order_select,
    output logic o_flow_through_select,
    output logic o_latency_mode_select,
    output logic o_snooze_request
);
    // ****************
    // pin levels
    // ****************
    initial begin
        {o_processor_address_strobe_n, o_controller_address_strobe_n, o_burst_advance_n} = 3'h7;
        {o_first_chip_select_n, o_second_chip_select, o_third_chip_select_n} = 3'h6;
        {o_global_write_all_n, o_byte_write_gate_n, o_byte_lane_enables_n} = 6'h3f;
        o_addr = 16'h0000;
        o_dq = 32'h00000000;
        o_output_drive_enable_n = 1'b1;
        {o_burst_order_select, o_flow_through_select, o_latency_mode_select} = 3'h0;
        o_snooze_request = 1'b0;
    end

    // ****************
    // bus tasks
    // ****************
    // static modes, changed only while reset holds
    task automatic set_modes(input logic [2:0] modes);
        {o_burst_order_select, o_flow_through_select, o_latency_mode_select} = modes;
    endtask

    task automatic set_snooze(input logic req);
        o_snooze_request = req;
    endtask

    // one cycle, driven just after the edge, held until the next
    task automatic bus_cycle(input logic [5:0] ctl, input logic [15:0] addr, input logic [31:0] data,
                             input logic [5:0] wctl, input logic oe_n);
        logic wr;
        @(posedge i_clk);
        #2;
        wr = (!wctl[5] || (!wctl[4] && wctl[3:0] != 4'hf)) && (ctl[5] || ctl[2]);
        {o_processor_address_strobe_n, o_controller_address_strobe_n, o_burst_advance_n,
         o_first_chip_select_n, o_second_chip_select, o_third_chip_select_n} = ctl;
        o_addr = addr;
        o_dq = wr ? data : ~o_dq;
        {o_global_write_all_n, o_byte_write_gate_n, o_byte_lane_enables_n} = wctl;
        o_output_drive_enable_n = oe_n | wr;
    endtask
endmodule

/* File: tb/sync_burst_sram_control_tb.sv */
// self-checking bench for the burst static memory control block
`timescale 1ns/1ps
`include "burst_sram_defines.svh"

module sync_burst_sram_control_tb;
    // ****************
    // pins and state
    // ****************
    localparam logic [5:0] c_rd = 6'h1a;
    localparam logic [5:0] c_wr = 6'h2a;
    localparam logic [5:0] c_cont = 6'h16;
    localparam logic [5:0] c_susp = 6'h3a;
    localparam logic [5:0] c_idle = 6'h3e;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] addr;
    logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic dq_oe;
    logic pstb_n, cstb_n, step_n, sel1_n, sel2, sel3_n, wall_n, wgate_n, oe_n;
    logic [3:0] lanes_n;
    logic ord_sel, flow_sel, lat_sel, snz_req, sel, snz;
    logic [31:0] exp_q[$];
    logic [31:0] mem_m [logic [15:0]];
    logic [31:0] lfsr = 32'h0000004f;
    int error_cnt = 0;
    int compares = 0;
    logic pipe, lat, ord;
    logic [5:0] desel;

    always #12.5 clk = ~clk;

    host_bus_model host_bus_model_inst (.i_clk(clk), .o_addr(addr), .o_dq(dq_in),
        .o_processor_address_strobe_n(pstb_n), .o_controller_address_strobe_n(cstb_n),
        .o_burst_advance_n(step_n), .o_first_chip_select_n(sel1_n), .o_second_chip_select(sel2),
        .o_third_chip_select_n(sel3_n), .o_global_write_all_n(wall_n), .o_byte_write_gate_n(wgate_n),
        .o_byte_lane_enables_n(lanes_n), .o_output_drive_enable_n(oe_n), .o_burst_order_select(ord_sel),
        .o_flow_through_select(flow_sel), .o_latency_mode_select(lat_sel), .o_snooze_request(snz_req));

    sync_burst_sram_control sync_burst_sram_control_inst (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_dq_in(dq_in), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_processor_address_strobe_n(pstb_n),
        .i_controller_address_strobe_n(cstb_n), .i_burst_advance_n(step_n), .i_first_chip_select_n(sel1_n),
        .i_second_chip_select(sel2), .i_third_chip_select_n(sel3_n), .i_global_write_all_n(wall_n),
        .i_byte_write_gate_n(wgate_n), .i_byte_lane_enables_n(lanes_n), .i_output_drive_enable_n(oe_n),
        .i_burst_order_select(ord_sel), .i_flow_through_select(flow_sel), .i_latency_mode_select(lat_sel),
        .i_snooze_request(snz_req), .o_selected(sel), .o_snooze_active(snz));

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [15:0] beat_addr(input logic [15:0] s, input logic [1:0] cnt);
        return {s[15:2], ord ? (s[1:0] ^ cnt) : (s[1:0] + cnt)};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic idle();
        host_bus_model_inst.bus_cycle(c_idle, 16'h0000, 32'h00000000, 6'h3f, 1'b0);
    endtask

    // last word of a read closed by deselect
    task automatic close_rd(input logic [31:0] w);
        repeat (pipe ? int'(lat) : 1 + int'(lat)) exp_q.push_back(w);
    endtask

    // six beats: start, step, hold, step, step, wrap
    task automatic burst(input logic wr, input logic [15:0] s);
        logic [1:0] cnt [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
        logic [15:0] a;
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            a = beat_addr(s, cnt[i]);
            d = rnd();
            if (wr) begin
                mem_m[a] = d;
            end else if (i < 5 && i != 3) begin
                exp_q.push_back(mem_m[a]);
            end
            host_bus_model_inst.bus_cycle(i == 0 ? (wr ? c_wr : c_rd) : (i == 2 ? c_susp : c_cont), a, d,
                (wr || i == 0) ? 6'h1f : 6'h3f, wr | (i == 3 + int'(pipe)));
            if (i == 1 && !wr) begin
                check("first word timing", {30'h0, dq_oe, sel}, {30'h0, !pipe, 1'b1});
            end
        end
        if (!wr) begin
            close_rd(mem_m[beat_addr(s, 2'h0)]);
        end
        host_bus_model_inst.bus_cycle(desel, s, 32'h0, 6'h3f, wr);
        idle();
        if (!lat) begin
            check("release after deselect", {31'h0, dq_oe}, 32'h0);
        end
        idle();
        check("bus closed", {30'h0, dq_oe, sel}, 32'h0);
    endtask

    // single access held one cycle, then closed
    task automatic op(input logic [5:0] ctl, input logic [15:0] a, input logic [5:0] w);
        logic [31:0] d;
        logic [31:0] m;
        logic rd;
        d = rnd();
        m = mem_m[a];
        rd = ctl == c_rd || (w[5] && (w[4] || w[3:0] == 4'hf));
        if (rd) begin
            exp_q.push_back(m);
            close_rd(m);
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (!w[5] || !w[b]) m[8*b +: 8] = d[8*b +: 8];
            end
            mem_m[a] = m;
        end
        host_bus_model_inst.bus_cycle(ctl, a, d, w, 1'b0);
        host_bus_model_inst.bus_cycle(c_susp, a, d, rd ? 6'h3f : w, 1'b0);
        host_bus_model_inst.bus_cycle(desel, a, d, 6'h3f, 1'b0);
        repeat (2) idle();
    endtask

    // ****************
    // output watcher
    // ****************
    always @(posedge clk) begin
        #1;
        if (dq_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare word", 32'h1, 32'h0);
            end else begin
                check("read word", dq_out, exp_q.pop_front());
            end
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        logic [15:0] s;
        logic [15:0] a;
        int n;
        for (int md = 0; md < 8; md++) begin
            {lat, ord, pipe} = md[2:0];
            desel = ord ? 6'h1b : 6'h18;
            rst_n = 1'b0;
            host_bus_model_inst.set_modes({ord, pipe, lat});
            repeat (8) idle();
            rst_n = 1'b1;
            check("reset outputs", {29'h0, dq_oe, sel, snz}, 32'h0);
            s = 16'(rnd());
            burst(1'b1, s);
            burst(1'b0, {s[15:2], lfsr[1:0]});
            a = 16'(rnd());
            for (int k = 0; k < 18; k++) begin
                op(c_wr, a, k == 16 ? 6'h1a : (k == 17 ? 6'h30 : {2'h2, k[3:0]}));
                op(c_rd, a, 6'h1f);
            end
            host_bus_model_inst.set_snooze(1'b1);
            repeat (2) idle();
            check("snooze entry", {31'h0, snz}, 32'h1);
            host_bus_model_inst.bus_cycle(c_wr, s, rnd(), 6'h1f, 1'b1);
            host_bus_model_inst.bus_cycle(desel, s, 32'h0, 6'h3f, 1'b1);
            host_bus_model_inst.set_snooze(1'b0);
            repeat (2) idle();
            check("wake period", {31'h0, snz}, 32'h1);
            for (n = 0; n < 20 && snz !== 1'b0; n++) begin
                idle();
            end
            if (n == 20) begin
                error_cnt++;
                final_report();
            end
            op(c_rd, s, 6'h3f);
        end
        check("words left", 32'(exp_q.size()), 32'h0);
        final_report();
    end
endmodule
